/* rtl/bist_tp_consts.vh */
// Constants shared by the self-test and test pattern block.
// Assumes an 8-bit register port with 8-bit addresses.
`ifndef BIST_TP_CONSTS_VH
`define BIST_TP_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_TEST_MODE 8'h0D
`define ADDR_SELF_TEST_CTRL 8'h0E
`define ADDR_OUT_MODE 8'h14
`define ADDR_USER_LOW 8'h19
`define ADDR_USER_HIGH 8'h20
`define ADDR_SIG_LOW 8'h24
`define ADDR_SIG_HIGH 8'h25
`define ADDR_LATE_INJECT 8'h62

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_BIST_START 0
`define BIT_BIST_RESUME 2
`define BIT_PN_LONG_RST 4
`define BIT_PN_SHORT_RST 5
`define BIT_OUT_INVERT 2

// ----------------------------------------
// Test mode codes
// ----------------------------------------
`define TM_OFF 4'h0
`define TM_MID 4'h1
`define TM_POS_FS 4'h2
`define TM_NEG_FS 4'h3
`define TM_CHECKER 4'h4
`define TM_PN_LONG 4'h5
`define TM_PN_SHORT 4'h6
`define TM_TOGGLE 4'h7
`define TM_USER 4'h8
`define TM_RAMP 4'hF

// ----------------------------------------
// Output formats and fixed words
// ----------------------------------------
`define FMT_TWOS 2'h0
`define FMT_OFFSET 2'h1
`define FMT_GRAY 2'h2
`define W_MID 14'h0000
`define W_POS_FS 14'h1FFF
`define W_NEG_FS 14'h2000
`define W_CHECK_A 14'h2AAA
`define W_CHECK_B 14'h1555
`define W_ONES 14'h3FFF
`define W_ZERO 14'h0000

// ----------------------------------------
// Generators, timing and reset values
// ----------------------------------------
`define PN_SHORT_SEED 9'h092
`define PN_LONG_SEED 23'h003AFF
`define BIST_SEED 9'h092
`define BIST_CYCLES 10'h200
`define SIG_SEED 16'hFFFF
`define SIG_POLY 16'h1021
`define REG_RESET 8'h00

`endif

/* rtl/pn_gen.v */
// Fibonacci pseudorandom generator, one bit per step.
// Assumes a synchronised active-low reset from the parent.
`timescale 1ns/1ps
`default_nettype none
module pn_gen #(
    parameter WIDTH = 9,
    parameter TAP = 5,
    parameter [WIDTH-1:0] SEED = 9'h092,
    parameter INVERT = 0
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Control
    input wire load_i,
    input wire step_i,
    // Stream
    output wire bit_o
);
    reg [WIDTH-1:0] state_r;
    wire fb = state_r[WIDTH-1] ^ state_r[TAP-1];

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= SEED;
        end else if (load_i) begin
            state_r <= SEED;
        end else if (step_i) begin
            state_r <= {state_r[WIDTH-2:0], fb};
        end
    end

    assign bit_o = (INVERT != 0) ? ~fb : fb;
endmodule // pn_gen
`default_nettype wire

/* rtl/out_format.v */
// Output formatter: twos complement, offset binary or Gray, optional invert.
// Input is a twos-complement sample; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "bist_tp_consts.vh"
module out_format #(
    parameter W = 14
) (
    // Sample in
    input wire [W-1:0] word_i,
    // Format select
    input wire [1:0] fmt_i,
    input wire invert_i,
    // Formatted sample
    output reg [W-1:0] word_o
);
    reg [W-1:0] src;
    reg [W-1:0] ofs;

    always @* begin
        src = invert_i ? ~word_i : word_i;
        ofs = {~src[W-1], src[W-2:0]};
        case (fmt_i)
            `FMT_OFFSET: word_o = ofs;
            // Gray coding is taken from the offset binary form
            `FMT_GRAY: word_o = ofs ^ (ofs >> 1);
            default: word_o = src;
        endcase
    end
endmodule // out_format
`default_nettype wire

/* rtl/datapath_bist_and_test_patterns.v */
// Datapath self-test, output test patterns and the serial sample lane.
// Assumes samples and register writes arrive on sys_clk_i (the encode clock).
`timescale 1ns/1ps
`default_nettype none
`include "bist_tp_consts.vh"
module datapath_bist_and_test_patterns #(
    parameter W = 14
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Converter samples
    input wire [W-1:0] adc_data_i,
    // Register port
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Serial sample lane
    output reg ser_bit_o,
    output reg ser_word_start_o,
    output reg [W-1:0] link_word_o,
    // Status
    output reg bist_busy_o
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_meta_r;
    reg rst_sync_r;
    wire rst_b = rst_sync_r;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [7:0] test_mode_r;
    reg [7:0] st_ctrl_r;
    reg [7:0] out_mode_r;
    reg [7:0] user_low_r;
    reg [7:0] user_high_r;
    reg [7:0] late_inject_r;
    reg [15:0] sig_r;
    wire [3:0] mode = test_mode_r[3:0];
    wire [3:0] late_mode = late_inject_r[3:0];
    wire bist_start = reg_wr_i && (reg_addr_i == `ADDR_SELF_TEST_CTRL) &&
                      reg_wdata_i[`BIT_BIST_START] && !bist_busy_o;

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            test_mode_r <= `REG_RESET;
            st_ctrl_r <= `REG_RESET;
            out_mode_r <= `REG_RESET;
            user_low_r <= `REG_RESET;
            user_high_r <= `REG_RESET;
            late_inject_r <= `REG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_TEST_MODE: test_mode_r <= reg_wdata_i;
                `ADDR_SELF_TEST_CTRL: st_ctrl_r <= reg_wdata_i;
                `ADDR_OUT_MODE: out_mode_r <= reg_wdata_i;
                `ADDR_USER_LOW: user_low_r <= reg_wdata_i;
                `ADDR_USER_HIGH: user_high_r <= reg_wdata_i;
                `ADDR_LATE_INJECT: late_inject_r <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Read data is registered; unmapped addresses read zero
    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `ADDR_TEST_MODE: reg_rdata_o <= test_mode_r;
                `ADDR_SELF_TEST_CTRL: reg_rdata_o <= {st_ctrl_r[7:1], bist_busy_o};
                `ADDR_OUT_MODE: reg_rdata_o <= out_mode_r;
                `ADDR_USER_LOW: reg_rdata_o <= user_low_r;
                `ADDR_USER_HIGH: reg_rdata_o <= user_high_r;
                `ADDR_SIG_LOW: reg_rdata_o <= sig_r[7:0];
                `ADDR_SIG_HIGH: reg_rdata_o <= sig_r[15:8];
                `ADDR_LATE_INJECT: reg_rdata_o <= late_inject_r;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Word timing
    // ----------------------------------------
    // One sample leaves the lane every W clocks; the lane runs one bit per clock.
    reg [3:0] bit_cnt_r;
    wire word_tick = (bit_cnt_r == W - 1);

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= word_tick ? 4'h0 : bit_cnt_r + 4'h1;
        end
    end

    // ----------------------------------------
    // Pseudorandom sources
    // ----------------------------------------
    reg bist_run_r;
    reg [9:0] bist_cnt_r;
    wire pn_short_bit;
    wire pn_long_bit;
    wire bist_bit;
    // reset bits hold generators at seed; unselected ones also rest at seed
    wire short_load = test_mode_r[`BIT_PN_SHORT_RST] || (mode != `TM_PN_SHORT);
    wire long_load = test_mode_r[`BIT_PN_LONG_RST] || (mode != `TM_PN_LONG);
    // restart from seed unless resume is selected
    wire bist_load = bist_start && !reg_wdata_i[`BIT_BIST_RESUME];

    pn_gen #(.WIDTH(9), .TAP(5), .SEED(`PN_SHORT_SEED), .INVERT(0)) u_pn_short (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .load_i(short_load),
        .step_i(1'b1),
        .bit_o(pn_short_bit)
    );

    pn_gen #(.WIDTH(23), .TAP(18), .SEED(`PN_LONG_SEED), .INVERT(1)) u_pn_long (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .load_i(long_load),
        .step_i(1'b1),
        .bit_o(pn_long_bit)
    );

    // self-test source, steps only while the run is active
    pn_gen #(.WIDTH(9), .TAP(5), .SEED(`BIST_SEED), .INVERT(0)) u_pn_bist (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .load_i(bist_load),
        .step_i(bist_run_r),
        .bit_o(bist_bit)
    );

    // Bits gather into words MSB first
    reg [W-1:0] short_word_r;
    reg [W-1:0] long_word_r;
    reg [W-1:0] bist_word_r;

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            short_word_r <= `W_ZERO;
            long_word_r <= `W_ZERO;
            bist_word_r <= `W_ZERO;
        end else begin
            // one bit per encode clock edge
            short_word_r <= {short_word_r[W-2:0], pn_short_bit};
            long_word_r <= {long_word_r[W-2:0], pn_long_bit};
            // Cleared at start so a restarted run repeats its signature
            if (bist_start) begin
                bist_word_r <= `W_ZERO;
            end else if (bist_run_r) begin
                bist_word_r <= {bist_word_r[W-2:0], bist_bit};
            end
        end
    end

    // ----------------------------------------
    // Alternating words
    // ----------------------------------------
    reg phase_r;
    reg [W-1:0] ramp_r;

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= 1'b0;
            ramp_r <= `W_ZERO;
        end else if (word_tick) begin
            // word 1 and word 2 alternate sample by sample
            phase_r <= ~phase_r;
            // ramp wraps naturally at the top code
            ramp_r <= ramp_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------
    // Pattern selection
    // ----------------------------------------
    reg [W-1:0] pat_word;
    reg pat_bypass;
    reg pat_active;
    wire [W-1:0] user_a = {user_low_r, 6'h00};
    wire [W-1:0] user_b = {user_high_r, 6'h00};

    // code decode, bypass marks unformatted patterns
    always @* begin
        pat_word = `W_ZERO;
        pat_bypass = 1'b0;
        pat_active = 1'b1;
        case (mode)
            `TM_MID: pat_word = `W_MID;
            `TM_POS_FS: pat_word = `W_POS_FS;
            `TM_NEG_FS: pat_word = `W_NEG_FS;
            `TM_CHECKER: begin
                pat_word = phase_r ? `W_CHECK_B : `W_CHECK_A;
                pat_bypass = 1'b1;
            end
            `TM_PN_LONG: pat_word = long_word_r;
            `TM_PN_SHORT: pat_word = short_word_r;
            `TM_TOGGLE: begin
                pat_word = phase_r ? `W_ZERO : `W_ONES;
                pat_bypass = 1'b1;
            end
            `TM_USER: pat_word = phase_r ? user_b : user_a;
            `TM_RAMP: begin
                pat_word = ramp_r;
                pat_bypass = 1'b1;
            end
            default: pat_active = 1'b0;
        endcase
    end

    // Late injection uses the same codes but never passes the formatter
    reg [W-1:0] late_word;
    reg late_active;

    always @* begin
        late_word = `W_ZERO;
        late_active = 1'b1;
        case (late_mode)
            `TM_MID: late_word = `W_MID;
            `TM_POS_FS: late_word = `W_POS_FS;
            `TM_NEG_FS: late_word = `W_NEG_FS;
            `TM_CHECKER: late_word = phase_r ? `W_CHECK_B : `W_CHECK_A;
            `TM_PN_LONG: late_word = long_word_r;
            `TM_PN_SHORT: late_word = short_word_r;
            `TM_TOGGLE: late_word = phase_r ? `W_ZERO : `W_ONES;
            `TM_USER: late_word = phase_r ? user_b : user_a;
            `TM_RAMP: late_word = ramp_r;
            default: late_active = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Datapath and formatting
    // ----------------------------------------
    wire [W-1:0] core_word;
    wire [W-1:0] fmt_word;
    reg [W-1:0] link_word;

    // source at the core output: self-test, pattern or samples
    assign core_word = bist_run_r ? bist_word_r : (pat_active ? pat_word : adc_data_i);

    out_format #(.W(W)) u_fmt (
        .word_i(core_word),
        .fmt_i(out_mode_r[1:0]),
        .invert_i(out_mode_r[`BIT_OUT_INVERT]),
        .word_o(fmt_word)
    );

    always @* begin
        if (late_active) begin
            link_word = late_word;
        end else if (pat_active && pat_bypass && !bist_run_r) begin
            link_word = pat_word;
        end else begin
            link_word = fmt_word;
        end
    end

    // ----------------------------------------
    // Self-test sequencing and signature
    // ----------------------------------------
    // Signature folds the formatted word every run cycle, so word phase cannot alter it.
    reg [15:0] misr_r;
    wire [15:0] misr_shift = {misr_r[14:0], 1'b0} ^ (misr_r[15] ? `SIG_POLY : 16'h0000);
    wire [15:0] misr_nxt = misr_shift ^ {2'b00, fmt_word};
    wire bist_last = (bist_cnt_r == `BIST_CYCLES - 10'h001);

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            bist_run_r <= 1'b0;
            bist_busy_o <= 1'b0;
            bist_cnt_r <= 10'h000;
            misr_r <= `SIG_SEED;
            sig_r <= 16'h0000;
        end else if (bist_start) begin
            bist_run_r <= 1'b1;
            bist_busy_o <= 1'b1;
            bist_cnt_r <= 10'h000;
            misr_r <= `SIG_SEED;
        end else if (bist_run_r) begin
            misr_r <= misr_nxt;
            if (bist_last) begin
                bist_run_r <= 1'b0;
                bist_busy_o <= 1'b0;
                sig_r <= misr_nxt;
            end else begin
                bist_cnt_r <= bist_cnt_r + 10'h001;
            end
        end
    end

    // ----------------------------------------
    // Serial lane
    // ----------------------------------------
    reg [W-1:0] shift_r;

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= `W_ZERO;
            ser_bit_o <= 1'b0;
            ser_word_start_o <= 1'b0;
            link_word_o <= `W_ZERO;
        end else begin
            ser_word_start_o <= word_tick;
            if (word_tick) begin
                shift_r <= link_word;
                link_word_o <= link_word;
                ser_bit_o <= link_word[W-1];
            end else begin
                shift_r <= {shift_r[W-2:0], 1'b0};
                ser_bit_o <= shift_r[W-2];
            end
        end
    end
endmodule // datapath_bist_and_test_patterns
`default_nettype wire

/* tb/bist_tp_props_properties.sv */
// Checker for the self-test and test pattern block, port view only.
// Assumes a bind from the bench top; one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none
module bist_tp_props #(
    parameter W = 14
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Inputs
    input wire [W-1:0] adc_data_i,
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    // Outputs
    input wire [7:0] reg_rdata_o,
    input wire ser_bit_o,
    input wire ser_word_start_o,
    input wire [W-1:0] link_word_o,
    input wire bist_busy_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    logic [10:0] busy_cnt_r;
    wire mapped_w = (reg_addr_i == 8'h0D) || (reg_addr_i == 8'h0E) || (reg_addr_i == 8'h14) ||
        (reg_addr_i == 8'h19) || (reg_addr_i == 8'h20) || (reg_addr_i == 8'h24) ||
        (reg_addr_i == 8'h25) || (reg_addr_i == 8'h62);

    // Counts busy cycles; a run longer than the limit would otherwise go unseen
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) busy_cnt_r <= 11'h000;
        else if (bist_busy_o) busy_cnt_r <= busy_cnt_r + 11'h001;
        else busy_cnt_r <= 11'h000;
    end

    sequence s_gap;
        (!ser_word_start_o)[*8] ##1 (!ser_word_start_o)[*5];
    endsequence
    sequence s_hold;
        $stable(link_word_o)[*8] ##1 $stable(link_word_o)[*5];
    endsequence

    property p_start_period;
        ser_word_start_o |=> s_gap ##1 ser_word_start_o;
    endproperty
    property p_word_stable;
        ser_word_start_o |=> s_hold;
    endproperty
    property p_msb_first;
        ser_word_start_o |-> ser_bit_o == link_word_o[W-1];
    endproperty
    property p_lsb_last;
        ser_word_start_o |-> ##13 (ser_bit_o == link_word_o[0]);
    endproperty
    property p_busy_len;
        $fell(bist_busy_o) |-> busy_cnt_r == 11'h200;
    endproperty
    property p_busy_max;
        bist_busy_o |-> busy_cnt_r < 11'h200;
    endproperty
    property p_busy_start;
        reg_wr_i && reg_addr_i == 8'h0E && reg_wdata_i[0] && !bist_busy_o |=> bist_busy_o;
    endproperty
    property p_busy_cause;
        $rose(bist_busy_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h0E;
    endproperty
    property p_unmapped;
        !mapped_w |=> reg_rdata_o == 8'h00;
    endproperty

    a_start_period: assert property (p_start_period) else $error("word start spacing wrong");
    a_word_stable: assert property (p_word_stable) else $error("link word changed mid word");
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");
    a_lsb_last: assert property (p_lsb_last) else $error("last bit is not the LSB");
    a_busy_len: assert property (p_busy_len) else $error("self-test length wrong");
    a_busy_max: assert property (p_busy_max) else $error("self-test overran");
    a_busy_start: assert property (p_busy_start) else $error("start write did not start");
    a_busy_cause: assert property (p_busy_cause) else $error("self-test started unasked");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // bist_tp_props
`default_nettype wire

/* tb/link_rx_model.sv */
// Receiver on the far side of the serial sample lane.
// Assumes the word-start marker flags the first bit of every word.
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Lane
    input wire logic ser_bit_i,
    input wire logic word_start_i,
    // Received word
    output logic [13:0] rx_word_o,
    output logic rx_valid_o
);
    logic [12:0] shift_r;
    logic [3:0] cnt_r;

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_r <= 13'h0000;
            cnt_r <= 4'h0;
            rx_word_o <= 14'h0000;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (word_start_i) begin
                shift_r <= {12'h000, ser_bit_i};
                cnt_r <= 4'h1;
            end else if (cnt_r == 4'hD) begin
                rx_word_o <= {shift_r, ser_bit_i};
                rx_valid_o <= 1'b1;
                cnt_r <= 4'h0;
            end else if (cnt_r != 4'h0) begin
                shift_r <= {shift_r[11:0], ser_bit_i};
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule // link_rx_model
`default_nettype wire

/* tb/datapath_bist_and_test_patterns_tb_top.sv */
// Bench top: drives registers and samples, receives the lane, checks words and signatures.
// Assumes the design files and the receiver model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module datapath_bist_and_test_patterns_tb_top;
    logic sys_clk_i, rst_b_i, reg_wr_i, ser_bit_o, ser_word_start_o, bist_busy_o, rx_valid;
    logic [13:0] adc_data_i, link_word_o, rx_word;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    int err_total, num_checks, seed;

    datapath_bist_and_test_patterns #(.W(14)) dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .adc_data_i(adc_data_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .ser_bit_o(ser_bit_o), .ser_word_start_o(ser_word_start_o),
        .link_word_o(link_word_o), .bist_busy_o(bist_busy_o));
    link_rx_model rx_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ser_bit_i(ser_bit_o),
        .word_start_i(ser_word_start_o), .rx_word_o(rx_word), .rx_valid_o(rx_valid));

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        repeat (2) @(posedge sys_clk_i);
        #1;
        d = reg_rdata_o;
    endtask
    task automatic get_word(output logic [13:0] w);
        w = 14'h0000;
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (rx_valid === 1'b1) begin
                w = rx_word;
                break;
            end
        end
    endtask
    // Two words are dropped so the first compared one is built after the change
    task automatic set_mode(input logic [7:0] md, input logic [7:0] f);
        logic [13:0] x;
        wr(8'h14, f);
        wr(8'h0D, md);
        get_word(x);
        get_word(x);
    endtask
    task automatic bist(input logic [7:0] ctl, output logic [15:0] sig);
        logic [7:0] lo, hi;
        int n;
        n = 0;
        wr(8'h0E, ctl);
        for (int i = 0; i < 600; i++) begin
            #1;
            if (bist_busy_o === 1'b1) n++;
            else if (n > 0) break;
            @(posedge sys_clk_i);
        end
        chk_reg(n[15:0], 16'h0200);
        rd(8'h24, lo);
        rd(8'h25, hi);
        sig = {hi, lo};
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [13:0] fmt(input logic [13:0] w, input int f);
        logic [13:0] o;
        o = w ^ 14'h2000;
        if (f == 1) return o;
        if (f == 2) return o ^ (o >> 1);
        return w;
    endfunction
    function automatic logic [13:0] cval(input int code);
        if (code == 2) return 14'h1FFF;
        if (code == 3) return 14'h2000;
        return 14'h0000;
    endfunction

    initial begin
        #(8 * 40000);
        err_total++;
        $display("watchdog expired");
        end_sim;
    end

    initial begin
        logic [7:0] d, u;
        logic [7:0] addrs [9];
        logic [7:0] pnm [4];
        logic [13:0] w1, w2, a, b;
        logic [15:0] s1, s2;
        addrs = '{8'h0D, 8'h0E, 8'h14, 8'h19, 8'h20, 8'h24, 8'h25, 8'h62, 8'h13};
        pnm = '{8'h26, 8'h15, 8'h06, 8'h05};
        seed = 51;
        err_total = 0;
        num_checks = 0;
        rst_b_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        adc_data_i = 14'h0000;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        foreach (addrs[i]) begin
            rd(addrs[i], d);
            chk_reg({8'h00, d}, 16'h0000);
        end
        $display("TEST reset_values done");
        for (int f = 0; f < 3; f++) for (int c = 1; c < 4; c++) begin
            adc_data_i <= $random(seed);
            set_mode(c[7:0], f[7:0]);
            get_word(w1);
            chk_word(w1, fmt(cval(c), f));
        end
        $display("TEST constants done");
        for (int f = 0; f < 3; f++) for (int m = 0; m < 3; m++) begin
            set_mode(m == 0 ? 8'h04 : (m == 1 ? 8'h07 : 8'h0F), f[7:0]);
            get_word(w1);
            get_word(w2);
            a = m == 0 ? 14'h2AAA : 14'h3FFF;
            if (m == 2) chk_word(w2, w1 + 14'h0001);
            else chk_word(w1 ^ w2, 14'h3FFF);
            if (m < 2) chk_word((w1 === a || w1 === ~a) ? a : w1, a);
        end
        $display("TEST alternating done");
        u = $random(seed);
        wr(8'h19, u);
        wr(8'h20, ~u);
        set_mode(8'h08, 8'h01);
        get_word(w1);
        get_word(w2);
        a = fmt({u, 6'h00}, 1);
        b = fmt({~u, 6'h00}, 1);
        chk_word(w1 === a ? w2 : w1, b);
        chk_word(w1 === a ? w1 : w2, a);
        $display("TEST user done");
        for (int i = 0; i < 7; i++) begin
            adc_data_i <= $random(seed);
            set_mode(i == 0 ? 8'h00 : 8'h08 + i[7:0], i % 3);
            get_word(w1);
            chk_word(w1, fmt(adc_data_i, i % 3));
        end
        $display("TEST off_unused done");
        foreach (pnm[i]) begin
            set_mode(pnm[i], 8'h00);
            get_word(w1);
            get_word(w2);
            chk_reg({15'h0000, w1 === w2}, {15'h0000, i < 2});
        end
        wr(8'h62, 8'h07);
        set_mode(8'h01, 8'h01);
        get_word(w1);
        get_word(w2);
        chk_word(w1 ^ w2, 14'h3FFF);
        wr(8'h62, 8'h00);
        $display("TEST pn_late done");
        set_mode(8'h00, 8'h00);
        bist(8'h01, s1);
        bist(8'h01, s2);
        chk_reg(s2, s1);
        bist(8'h05, s2);
        chk_reg({15'h0000, s2 !== s1}, 16'h0001);
        wr(8'h14, 8'h02);
        bist(8'h01, s2);
        chk_reg({15'h0000, s2 !== s1}, 16'h0001);
        wr(8'h24, 8'hAA);
        rd(8'h24, d);
        chk_reg({8'h00, d}, {8'h00, s2[7:0]});
        $display("TEST self_test done");
        end_sim;
    end
endmodule // datapath_bist_and_test_patterns_tb_top

bind datapath_bist_and_test_patterns bist_tp_props #(.W(W)) props_u (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .adc_data_i(adc_data_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ser_bit_o(ser_bit_o),
    .ser_word_start_o(ser_word_start_o), .link_word_o(link_word_o), .bist_busy_o(bist_busy_o));
`default_nettype wire
